// [inc/spcbr_regs.svh]
// offsets, field positions and reset values of the sensor
// power, clock and bias register bank; definitions only
`ifndef SPCBR_REGS_SVH
`define SPCBR_REGS_SVH

// ***********************************************************
// register offsets on the configuration port
// ***********************************************************
`define SPCBR_OFF_CLOCK_GENERATOR_CONFIG 9'h020
`define SPCBR_OFF_GENERAL_LOGIC_CONFIG 9'h022
`define SPCBR_OFF_IMAGE_CORE_POWER 9'h028
`define SPCBR_OFF_IMAGE_CORE_LEVELS 9'h029
`define SPCBR_OFF_FRONTEND_POWER 9'h030
`define SPCBR_OFF_BANDGAP_POWER 9'h040
`define SPCBR_OFF_BIAS_CONFIGURATION 9'h041
`define SPCBR_OFF_FRONTEND_CURRENT_SETTINGS 9'h042
`define SPCBR_OFF_COLUMN_MUX_CURRENT_SETTINGS 9'h043
`define SPCBR_OFF_SERIAL_OUTPUT_CURRENT_SETTINGS 9'h044

// ***********************************************************
// reset values
// ***********************************************************
`define SPCBR_RST_CLOCK_GENERATOR_CONFIG 16'h0004
`define SPCBR_RST_GENERAL_LOGIC_CONFIG 16'h0000
`define SPCBR_RST_IMAGE_CORE_POWER 16'h0000
`define SPCBR_RST_IMAGE_CORE_LEVELS 16'h0b5a
`define SPCBR_RST_FRONTEND_POWER 16'h0000
`define SPCBR_RST_BANDGAP_POWER 16'h0000
`define SPCBR_RST_BIAS_CONFIGURATION 16'h888b
`define SPCBR_RST_FRONTEND_CURRENT_SETTINGS 16'h53c8
`define SPCBR_RST_COLUMN_MUX_CURRENT_SETTINGS 16'h8888
`define SPCBR_RST_SERIAL_OUTPUT_CURRENT_SETTINGS 16'h0088

// ***********************************************************
// field positions
// ***********************************************************
`define SPCBR_BIT_ANALOG_CLK_EN 0
`define SPCBR_BIT_LOGIC_CLK_EN 1
`define SPCBR_BIT_SELECT_PLL 2
`define SPCBR_BIT_ADC_8BIT 3
`define SPCBR_BIT_LOGIC_EN 0
`define SPCBR_BIT_CORE_PWR_UP 0
`define SPCBR_BIT_MUX_PWR_UP 1
`define SPCBR_BIT_COLBIAS_EN 2
`define SPCBR_FLD_DOUBLE_SLOPE_LEVEL 3:0
`define SPCBR_FLD_TRIPLE_SLOPE_LEVEL 7:4
`define SPCBR_BIT_AFE_PWR_UP 0
`define SPCBR_BIT_BANDGAP_PWR_UP 0
`define SPCBR_BIT_EXT_RESISTOR 0
`define SPCBR_FLD_PRECHARGE_TRIM 7:4
`define SPCBR_FLD_COLBIAS_TRIM 11:8
`define SPCBR_FLD_PUMP_CURRENT_TRIM 15:12
`define SPCBR_FLD_MUX_FIRST_STAGE_TRIM 3:0
`define SPCBR_FLD_MUX_SECOND_STAGE_TRIM 7:4

`endif

// [inc/spcbr_pkg.sv]
// types shared by the sensor power, clock and bias register bank
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package spcbr_pkg;

  // ***********************************************************
  // basic types
  // ***********************************************************
  typedef logic [15:0] spcbr_word_t;
  typedef logic [8:0] spcbr_addr_t;
  typedef logic [3:0] spcbr_trim_t;

  // ***********************************************************
  // configuration port request
  // ***********************************************************
  typedef struct packed {
    spcbr_addr_t addr;
    spcbr_word_t wdata;
    logic wr;
    logic rd;
  } spcbr_bus_s;

  // ***********************************************************
  // decoded controls toward the analog and clock blocks
  // ***********************************************************
  typedef struct packed {
    logic analog_clk_en;
    logic logic_clk_en;
    logic select_pll;
    logic adc_8bit;
    logic logic_en;
    logic core_pwr_up;
    logic mux_pwr_up;
    logic colbias_en;
    spcbr_trim_t double_slope_level;
    spcbr_trim_t triple_slope_level;
    logic afe_pwr_up;
    logic bandgap_pwr_up;
    logic ext_resistor;
    spcbr_trim_t precharge_trim;
    spcbr_trim_t colbias_trim;
    spcbr_trim_t pump_current_trim;
    spcbr_trim_t mux_first_stage_trim;
    spcbr_trim_t mux_second_stage_trim;
    spcbr_word_t frontend_currents;
    spcbr_word_t serial_currents;
  } spcbr_ctrl_s;

endpackage

`default_nettype wire

// [hw/spcbr_regs_top.sv]
// sensor power, clock and bias register bank
// assumes a host on REF_CLK driving one-cycle strobes on BUS
`include "spcbr_regs.svh"
`default_nettype none

module spcbr_regs_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire spcbr_pkg::spcbr_bus_s BUS,
  output logic [15:0] RDATA,
  output spcbr_pkg::spcbr_ctrl_s CTRL
);

  // ***********************************************************
  // register map tables
  // ***********************************************************
  localparam int NREG = 10;
  localparam spcbr_pkg::spcbr_addr_t OFFS [NREG] = '{
    `SPCBR_OFF_CLOCK_GENERATOR_CONFIG,
    `SPCBR_OFF_GENERAL_LOGIC_CONFIG,
    `SPCBR_OFF_IMAGE_CORE_POWER,
    `SPCBR_OFF_IMAGE_CORE_LEVELS,
    `SPCBR_OFF_FRONTEND_POWER,
    `SPCBR_OFF_BANDGAP_POWER,
    `SPCBR_OFF_BIAS_CONFIGURATION,
    `SPCBR_OFF_FRONTEND_CURRENT_SETTINGS,
    `SPCBR_OFF_COLUMN_MUX_CURRENT_SETTINGS,
    `SPCBR_OFF_SERIAL_OUTPUT_CURRENT_SETTINGS
  };
  localparam spcbr_pkg::spcbr_word_t RSTV [NREG] = '{
    `SPCBR_RST_CLOCK_GENERATOR_CONFIG,
    `SPCBR_RST_GENERAL_LOGIC_CONFIG,
    `SPCBR_RST_IMAGE_CORE_POWER,
    `SPCBR_RST_IMAGE_CORE_LEVELS,
    `SPCBR_RST_FRONTEND_POWER,
    `SPCBR_RST_BANDGAP_POWER,
    `SPCBR_RST_BIAS_CONFIGURATION,
    `SPCBR_RST_FRONTEND_CURRENT_SETTINGS,
    `SPCBR_RST_COLUMN_MUX_CURRENT_SETTINGS,
    `SPCBR_RST_SERIAL_OUTPUT_CURRENT_SETTINGS
  };

  // entry indices into the tables above
  localparam int I_CLK = 0;
  localparam int I_GEN = 1;
  localparam int I_IMP = 2;
  localparam int I_IML = 3;
  localparam int I_AFE = 4;
  localparam int I_BGP = 5;
  localparam int I_BCF = 6;
  localparam int I_AFC = 7;
  localparam int I_MUX = 8;
  localparam int I_SER = 9;

  spcbr_pkg::spcbr_word_t regs_r [NREG];
  logic [NREG-1:0] hit;
  spcbr_pkg::spcbr_word_t rdata_nxt;
  spcbr_pkg::spcbr_word_t rdata_r;

  // ***********************************************************
  // storage, one word per entry
  // ***********************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      // address decode for this entry
      assign hit[gi] = (BUS.addr == OFFS[gi]);

      // whole-word write, reserved bits kept as written
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          regs_r[gi] <= RSTV[gi];
        end else if (BUS.wr && hit[gi]) begin
          regs_r[gi] <= BUS.wdata;
        end
      end
    end
  endgenerate

  // ***********************************************************
  // read path
  // ***********************************************************
  // select the addressed word; unmapped reads give zero
  always_comb begin
    rdata_nxt = 16'h0000;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rdata_nxt = regs_r[i];
      end
    end
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rdata_r <= 16'h0000;
    end else if (BUS.rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign RDATA = rdata_r;

  // ***********************************************************
  // decoded controls
  // ***********************************************************
  // clock generator and general logic
  always_comb begin
    CTRL = '0;
    CTRL.analog_clk_en =
      regs_r[I_CLK][`SPCBR_BIT_ANALOG_CLK_EN];
    CTRL.logic_clk_en = regs_r[I_CLK][`SPCBR_BIT_LOGIC_CLK_EN];
    CTRL.select_pll = regs_r[I_CLK][`SPCBR_BIT_SELECT_PLL];
    CTRL.adc_8bit = regs_r[I_CLK][`SPCBR_BIT_ADC_8BIT];
    CTRL.logic_en = regs_r[I_GEN][`SPCBR_BIT_LOGIC_EN];
    // image core power and levels
    CTRL.core_pwr_up = regs_r[I_IMP][`SPCBR_BIT_CORE_PWR_UP];
    CTRL.mux_pwr_up = regs_r[I_IMP][`SPCBR_BIT_MUX_PWR_UP];
    CTRL.colbias_en = regs_r[I_IMP][`SPCBR_BIT_COLBIAS_EN];
    CTRL.double_slope_level =
      regs_r[I_IML][`SPCBR_FLD_DOUBLE_SLOPE_LEVEL];
    CTRL.triple_slope_level =
      regs_r[I_IML][`SPCBR_FLD_TRIPLE_SLOPE_LEVEL];
    // front ends and bias
    CTRL.afe_pwr_up = regs_r[I_AFE][`SPCBR_BIT_AFE_PWR_UP];
    CTRL.bandgap_pwr_up =
      regs_r[I_BGP][`SPCBR_BIT_BANDGAP_PWR_UP];
    CTRL.ext_resistor = regs_r[I_BCF][`SPCBR_BIT_EXT_RESISTOR];
    CTRL.precharge_trim =
      regs_r[I_BCF][`SPCBR_FLD_PRECHARGE_TRIM];
    CTRL.colbias_trim = regs_r[I_BCF][`SPCBR_FLD_COLBIAS_TRIM];
    CTRL.pump_current_trim =
      regs_r[I_BCF][`SPCBR_FLD_PUMP_CURRENT_TRIM];
    CTRL.mux_first_stage_trim =
      regs_r[I_MUX][`SPCBR_FLD_MUX_FIRST_STAGE_TRIM];
    CTRL.mux_second_stage_trim =
      regs_r[I_MUX][`SPCBR_FLD_MUX_SECOND_STAGE_TRIM];
    CTRL.frontend_currents = regs_r[I_AFC];
    CTRL.serial_currents = regs_r[I_SER];
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // marks the first cycle after reset release
  logic settled_r;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      settled_r <= 1'b0;
    end else begin
      settled_r <= 1'b1;
    end
  end

  // marks a write to the level register since reset
  logic lvl_written_r;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lvl_written_r <= 1'b0;
    end else if (BUS.wr && hit[I_IML]) begin
      lvl_written_r <= 1'b1;
    end
  end

  sequence s_wr(spcbr_pkg::spcbr_addr_t a);
    BUS.wr && BUS.addr == a;
  endsequence

  sequence s_rd(spcbr_pkg::spcbr_addr_t a);
    BUS.rd && BUS.addr == a;
  endsequence

  chk_clk_analog: assert property (
    s_wr(`SPCBR_OFF_CLOCK_GENERATOR_CONFIG) |=>
      CTRL.analog_clk_en == $past(BUS.wdata[0]))
    else $error("analog clock enable not updated");

  chk_clk_logic: assert property (
    s_wr(`SPCBR_OFF_CLOCK_GENERATOR_CONFIG) |=>
      CTRL.logic_clk_en == $past(BUS.wdata[1]))
    else $error("logic clock enable not updated");

  chk_clk_defaults: assert property (
    !settled_r |-> CTRL.select_pll && !CTRL.analog_clk_en &&
      !CTRL.logic_clk_en && !CTRL.adc_8bit)
    else $error("clock generator reset value wrong");

  chk_adc_width: assert property (
    s_wr(`SPCBR_OFF_CLOCK_GENERATOR_CONFIG) |=>
      CTRL.adc_8bit == $past(BUS.wdata[3]) &&
      CTRL.select_pll == $past(BUS.wdata[2]))
    else $error("conversion width or source wrong");

  chk_logic_enable: assert property (
    $rose(CTRL.logic_en) |->
      $past(BUS.wr && BUS.addr == `SPCBR_OFF_GENERAL_LOGIC_CONFIG))
    else $error("logic enable rose without a write");

  chk_core_power: assert property (
    s_wr(`SPCBR_OFF_IMAGE_CORE_POWER) |=>
      {CTRL.colbias_en, CTRL.mux_pwr_up, CTRL.core_pwr_up}
        == $past(BUS.wdata[2:0]))
    else $error("image core power bits wrong");

  chk_core_hold: assert property (
    !(BUS.wr && BUS.addr == `SPCBR_OFF_IMAGE_CORE_POWER) |=>
      $stable(CTRL.mux_pwr_up) && $stable(CTRL.colbias_en))
    else $error("image core bits moved without a write");

  chk_level_defaults: assert property (
    !settled_r |-> CTRL.double_slope_level == 4'ha &&
      CTRL.triple_slope_level == 4'h5)
    else $error("slope level reset value wrong");

  chk_power_defaults: assert property (
    !settled_r |-> !CTRL.afe_pwr_up && !CTRL.bandgap_pwr_up &&
      !CTRL.core_pwr_up && !CTRL.logic_en)
    else $error("power-down reset value wrong");

  chk_bias_defaults: assert property (
    !settled_r |-> CTRL.ext_resistor &&
      CTRL.precharge_trim == 4'h8 && CTRL.colbias_trim == 4'h8 &&
      CTRL.pump_current_trim == 4'h8)
    else $error("bias configuration reset value wrong");

  chk_mux_trims: assert property (
    s_wr(`SPCBR_OFF_COLUMN_MUX_CURRENT_SETTINGS) |=>
      CTRL.mux_first_stage_trim == $past(BUS.wdata[3:0]) &&
      CTRL.mux_second_stage_trim == $past(BUS.wdata[7:4]))
    else $error("mux stage trims wrong");

  chk_readback_word: assert property (
    s_wr(`SPCBR_OFF_BIAS_CONFIGURATION) ##1
      s_rd(`SPCBR_OFF_BIAS_CONFIGURATION) |=>
      RDATA == $past(BUS.wdata, 2))
    else $error("bias word readback differs from write");

  chk_read_default: assert property (
    (!lvl_written_r and s_rd(`SPCBR_OFF_IMAGE_CORE_LEVELS)) |=>
      RDATA == 16'h0b5a)
    else $error("level register default read wrong");

  chk_read_idle: assert property (
    !BUS.rd |=> RDATA == 16'h0000)
    else $error("read data outside the answer cycle");

endmodule

`default_nettype wire

// [testbench/spcbr_host_model.sv]
// host model driving the register bank configuration port
// assumes REF_CLK from the bench and read data one cycle later
`default_nettype none

module spcbr_host_model (
  input wire logic REF_CLK,
  output spcbr_pkg::spcbr_bus_s BUS,
  input wire logic [15:0] RDATA
);
  timeunit 1ns;
  timeprecision 100ps;

  // ***********************************************************
  // bus cycles
  // ***********************************************************
  // idle port from time zero
  initial BUS = '0;

  // one request launched right after a rising edge
  task automatic req(input logic [8:0] a, input logic [15:0] d,
                     input logic w);
    @(posedge REF_CLK);
    BUS <= '{addr: a, wdata: d, wr: w, rd: ~w};
  endtask

  // drop the strobe, take the answer and the idle value after it
  task automatic finish(output logic [15:0] d, output logic [15:0] idle);
    @(posedge REF_CLK);
    BUS <= '0;
    #1 d = RDATA;
    @(posedge REF_CLK);
    #1 idle = RDATA;
  endtask

  task automatic write(input logic [8:0] a, input logic [15:0] d);
    req(a, d, 1'b1);
    @(posedge REF_CLK);
    BUS <= '0;
    // let the stored word settle before the caller looks
    #1;
  endtask

  task automatic read(input logic [8:0] a, output logic [15:0] d,
                      output logic [15:0] idle);
    req(a, 16'h0000, 1'b0);
    finish(d, idle);
  endtask

  // write then read the same place with no gap
  task automatic write_read(input logic [8:0] a, input logic [15:0] wd,
                            output logic [15:0] d, output logic [15:0] idle);
    req(a, wd, 1'b1);
    req(a, 16'h0000, 1'b0);
    finish(d, idle);
  endtask

  // read-modify-write of one field, other bits written back as read
  task automatic set_field(input logic [8:0] a, input int lsb, input int w,
                           input logic [15:0] v);
    logic [15:0] d;
    logic [15:0] idle;
    logic [15:0] m;
    read(a, d, idle);
    m = ((16'h0001 << w) - 16'h0001) << lsb;
    write(a, (d & ~m) | ((v << lsb) & m));
  endtask
endmodule

`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the sensor power, clock and bias bank
// assumes the host model file and the design package compiled first
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk;
  logic rst;
  spcbr_pkg::spcbr_bus_s bus;
  logic [15:0] rdata;
  spcbr_pkg::spcbr_ctrl_s ctrl;
  int mismatches = 0;
  int checks = 0;
  int seed = 87;
  logic [15:0] model[int];
  logic [8:0] addrs[10] = '{9'h020, 9'h022, 9'h028, 9'h029, 9'h030,
    9'h040, 9'h041, 9'h042, 9'h043, 9'h044};
  logic [15:0] rstv[10] = '{16'h0004, 16'h0000, 16'h0000, 16'h0b5a,
    16'h0000, 16'h0000, 16'h888b, 16'h53c8, 16'h8888, 16'h0088};
  logic [8:0] fa[19] = '{9'h020, 9'h020, 9'h020, 9'h020, 9'h022, 9'h028,
    9'h028, 9'h028, 9'h030, 9'h040, 9'h041, 9'h029, 9'h029, 9'h041,
    9'h041, 9'h041, 9'h043, 9'h043, 9'h029};
  int fl[19] = '{0, 1, 2, 3, 0, 0, 1, 2, 0, 0, 0, 0, 4, 4, 8, 12, 0, 4, 8};
  int fw[19] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 4, 4, 4, 4, 4, 4, 4, 8};
  logic [15:0] d;
  logic [15:0] idle;
  logic [15:0] m;
  int i;

  spcbr_regs_top dut_u (.REF_CLK(ref_clk), .RST(rst), .BUS(bus),
    .RDATA(rdata), .CTRL(ctrl));
  spcbr_host_model host_u (.REF_CLK(ref_clk), .BUS(bus), .RDATA(rdata));

  // ***********************************************************
  // reference model and checking
  // ***********************************************************
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // decoded controls expected from the model words
  function automatic spcbr_pkg::spcbr_ctrl_s exp_ctrl();
    spcbr_pkg::spcbr_ctrl_s e;
    e.analog_clk_en = model['h20][0];
    e.logic_clk_en = model['h20][1];
    e.select_pll = model['h20][2];
    e.adc_8bit = model['h20][3];
    e.logic_en = model['h22][0];
    e.core_pwr_up = model['h28][0];
    e.mux_pwr_up = model['h28][1];
    e.colbias_en = model['h28][2];
    e.double_slope_level = model['h29][3:0];
    e.triple_slope_level = model['h29][7:4];
    e.afe_pwr_up = model['h30][0];
    e.bandgap_pwr_up = model['h40][0];
    e.ext_resistor = model['h41][0];
    e.precharge_trim = model['h41][7:4];
    e.colbias_trim = model['h41][11:8];
    e.pump_current_trim = model['h41][15:12];
    e.mux_first_stage_trim = model['h43][3:0];
    e.mux_second_stage_trim = model['h43][7:4];
    e.frontend_currents = model['h42];
    e.serial_currents = model['h44];
    return e;
  endfunction

  // read every register and compare words, idle value and controls
  task automatic check_all();
    for (int k = 0; k < 10; k++) begin
      host_u.read(addrs[k], d, idle);
      check(d, model[addrs[k]]);
      check(idle, 16'h0000);
    end
    check(ctrl, exp_ctrl());
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ***********************************************************
  // clock, watchdog and main sequence
  // ***********************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    for (int k = 0; k < 10; k++) model[addrs[k]] = rstv[k];
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    check_all();
    $display("test reset_values done");
    // unmapped places ignore writes and read as zero
    foreach (fa[k]) begin
      host_u.write_read(fa[k] ^ 9'h101, 16'($random(seed)), d, idle);
      check(d, 16'h0000);
    end
    check_all();
    $display("test unmapped done");
    // random whole words, read back in the very next cycle
    host_u.write_read(9'h041, 16'h5a3c, d, idle);
    model[9'h041] = 16'h5a3c;
    check(d, 16'h5a3c);
    repeat (30) begin
      i = ($random(seed) & 32'h7fffffff) % 10;
      m = 16'($random(seed));
      host_u.write_read(addrs[i], m, d, idle);
      model[addrs[i]] = m;
      check(d, m);
      check(idle, 16'h0000);
      check(ctrl, exp_ctrl());
    end
    check_all();
    $display("test random_words done");
    // each field set to all ones, then cleared
    for (int k = 0; k < 19; k++) begin
      for (int v = 1; v >= 0; v--) begin
        m = ((16'h0001 << fw[k]) - 16'h0001) << fl[k];
        host_u.set_field(fa[k], fl[k], fw[k], v ? 16'hffff : 16'h0000);
        model[fa[k]] = v ? (model[fa[k]] | m) : (model[fa[k]] & ~m);
        check(ctrl, exp_ctrl());
      end
    end
    check_all();
    $display("test fields done");
    // reset in mid-run brings back every default
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 10; k++) model[addrs[k]] = rstv[k];
    check_all();
    $display("test second_reset done");
    final_report();
  end
endmodule

`default_nettype wire
